// ### handler_chk_sva.sv
// Port-level checks of the handler sort result interface
`timescale 1ns/1ps
`default_nettype none
module handler_chk
  import handler_pkg::*;
(
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         ce,
  // APB
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  // Handler pins and keys
  input wire logic         external_start_pulse_n,
  input wire logic         panel_lockout_n,
  input wire logic [7:0]   panel_keys,
  input wire logic [7:0]   panel_keys_gated,
  input wire logic         measure_start,
  input wire result_pins_t result_pins,
  input wire logic         analog_done_n,
  input wire logic         cycle_done_n,
  input wire logic         fault_alert_n,
  input wire logic         trigger_accept_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
    else $error("pready late");
  AST_ALARM_RESET: assert property (!$past(presetn) |-> ##[1:2] !fault_alert_n)
    else $error("alarm not raised by reset");
  AST_START_EDGE: assert property (measure_start |-> external_start_pulse_n &&
    !(&{$past(external_start_pulse_n, 3), $past(external_start_pulse_n, 4),
        $past(external_start_pulse_n, 5), $past(external_start_pulse_n, 6)}))
    else $error("start without rising edge");
  AST_START_ONE: assert property (measure_start |=> !measure_start)
    else $error("start pulse too long");
  AST_START_WAITING: assert property (measure_start |-> !$past(trigger_accept_n))
    else $error("start while not waiting");
  AST_ACCEPT_DROP: assert property (measure_start |=> trigger_accept_n)
    else $error("accept held after start");
  AST_DONE_CLEAR: assert property (measure_start |-> ##[1:2] analog_done_n && cycle_done_n)
    else $error("done flags kept over start");
  AST_RESULT_HOLD: assert property (!cycle_done_n && !$past(cycle_done_n) |-> $stable(result_pins))
    else $error("results moved during cycle done");
  AST_KEYS_LOCKED: assert property (!panel_lockout_n [*5] |-> panel_keys_gated == 8'h00)
    else $error("keys pass under lockout");
  AST_KEYS_FREE: assert property (panel_lockout_n [*5] |-> panel_keys_gated == $past(panel_keys))
    else $error("keys lost without lockout");
endmodule : handler_chk

bind handler_sort_result_interface handler_chk u_chk (
  .pclk, .presetn, .ce, .psel, .penable, .pready, .external_start_pulse_n, .panel_lockout_n,
  .panel_keys, .panel_keys_gated, .measure_start, .result_pins, .analog_done_n,
  .cycle_done_n, .fault_alert_n, .trigger_accept_n
);
`default_nettype wire

// ### handler_model.sv
// Handler partner: start pulses, lockout level, result capture at cycle end
`timescale 1ns/1ps
`default_nettype none
module handler_model
  import handler_pkg::*;
(
  // Clock
  input wire logic         pclk,
  // Towards the device, active low
  output logic             external_start_pulse_n,
  output logic             panel_lockout_n,
  // From the device
  input wire result_pins_t result_pins,
  input wire logic         cycle_done_n
);
  result_pins_t seen = PINS_IDLE;

  initial
  begin
    external_start_pulse_n = 1'b1;
    panel_lockout_n        = 1'b1;
  end

  // Results are taken only at cycle done; analog done just frees the fixture
  always @(posedge pclk)
    if (!cycle_done_n)
      seen <= result_pins;

  // Low for n cycles; the release is the trigger edge
  task automatic pulse(input int n);
    external_start_pulse_n <= 1'b0;
    repeat (n) @(posedge pclk);
    external_start_pulse_n <= 1'b1;
  endtask : pulse

  task automatic lock(input logic on);
    panel_lockout_n <= !on;
  endtask : lock
endmodule : handler_model
`default_nettype wire

// ### handler_pkg.sv
// Package: constants, register map and carrier types of the handler sort result interface
package handler_pkg;

  localparam int          CLK_HZ          = 20_000_000;
  localparam int          TRIG_MIN_NS     = 1000;
  // Least external start pulse width in cycles, rounded up
  localparam int          TRIG_MIN_CYC    = (TRIG_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic [11:0] OFF_CTRL        = 12'h000;
  localparam logic [11:0] OFF_RESULT      = 12'h004;
  localparam logic [11:0] OFF_STROBE      = 12'h008;
  localparam logic [11:0] OFF_STATUS      = 12'h00C;
  localparam logic [11:0] OFF_IRQ_STAT    = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h014;

  // CTRL fields
  localparam int          CTRL_EXTERNAL_START_PULSE   = 0;
  localparam int          CTRL_LIST_MODE  = 1;
  localparam int          CTRL_ARMED      = 2;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

  // STROBE fields (write-one pulses)
  localparam int          STB_ANALOG_DONE = 0;
  localparam int          STB_CYCLE_DONE  = 1;
  localparam int          STB_POWER_FAIL  = 2;
  localparam int          STB_ALARM_CLR   = 3;
  localparam int          STB_NEW_CYCLE   = 4;

  // Interrupt status bits
  localparam int          IRQ_TRIG        = 0;
  localparam int          IRQ_KEYLOCK     = 1;
  localparam int          IRQ_NUM         = 2;
  localparam logic [1:0]  IRQ_RESET       = 2'h0;

  localparam int          CLASS_N         = 9;

  // Result word: class code in [3:0] (1..9 class, 10 no match, 11 auxiliary),
  // flags above; list mode uses the sweep_bits field above the flags as sweep pass/fail data
  typedef struct packed {
    logic [9:0] sweep_bits;
    logic       overload;
    logic       sec_reject;
    logic       prim_below;
    logic       prim_above;
    logic [3:0] class_code;
  } result_t;

  localparam logic [3:0]  CODE_NO_MATCH   = 4'hA;
  localparam logic [3:0]  CODE_AUX        = 4'hB;

  typedef struct packed {
    logic [CLASS_N-1:0] sort_class_n;
    logic               no_class_match_n;
    logic               aux_class_n;
    logic               primary_above_limit_n;
    logic               primary_below_limit_n;
    logic               secondary_reject_n;
    logic               measure_overload_n;
  } result_pins_t;

  localparam result_pins_t PINS_IDLE = '1;

endpackage : handler_pkg

// ### handler_sort_result_interface.sv
// Handler interface: APB registers driving active-low sort result and control pins
//
// Overview of operation
// - Every slash-named handler line is active low; asserted means driven low.
// - Comparator mode reports the sort on one of nine classes, no-match or aux.
// - Comparator mode flags primary above upper and below lower limit.
// - Comparator mode flags secondary out of limits and measurement overload.
// - Analog-done asserts when the analog part of measuring is complete.
// - Cycle-done asserts when the whole cycle ends and results are valid.
// - Fault alert asserts on momentary power loss and after interface reset.
// - Trigger-accept output shows when the device can take a trigger.
// - External trigger mode starts measuring on the start pulse rising edge.
// - While panel lockout is asserted all front panel keys are ignored.
// - List sweep mode outputs per-sweep in/out and continuous compare results.
// - Meaning of result outputs and inputs follows the selected comparator mode.
// - Trigger-accept only while waiting for trigger, never with internal trigger.
`timescale 1ns/1ps
`default_nettype none
module handler_sort_result_interface
  import handler_pkg::*;
(
  // Clock, reset, enable
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  output logic              irq,
  // Handler inputs (active low, asynchronous)
  input  wire logic         external_start_pulse_n,
  input  wire logic         panel_lockout_n,
  // Front panel keys from the instrument
  input  wire logic [7:0]   panel_keys,
  output logic [7:0]        panel_keys_gated,
  // Measurement start towards the instrument
  output logic              measure_start,
  // Handler outputs (active low)
  output result_pins_t      result_pins,
  output logic              analog_done_n,
  output logic              cycle_done_n,
  output logic              fault_alert_n,
  output logic              trigger_accept_n
);

  logic [31:0]   ctrl;
  result_t       result;
  result_pins_t  next_pins;
  logic [IRQ_NUM-1:0] irq_stat;
  logic [IRQ_NUM-1:0] irq_mask;
  logic          trig_level;
  logic          trig_rise;
  logic          lock_level;
  logic          lock_rise;
  logic          analog_done;
  logic          cycle_done;
  logic          alarm;
  logic [7:0]    pulse_cnt;
  logic          pulse_ok;

  wire access    = psel & penable & ce;
  wire wr        = access & pwrite;
  wire ext_mode  = ctrl[CTRL_EXTERNAL_START_PULSE];
  wire list_mode = ctrl[CTRL_LIST_MODE];
  wire armed     = ctrl[CTRL_ARMED];
  wire stb_wr    = wr & (paddr == OFF_STROBE);
  // A start and a new-cycle strobe both open a fresh cycle
  wire new_cycle = measure_start | (stb_wr & pready & pwdata[STB_NEW_CYCLE]);

  function automatic logic addr_valid(input logic [11:0] a);
    return (a == OFF_CTRL) || (a == OFF_RESULT) || (a == OFF_STROBE) ||
           (a == OFF_STATUS) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
  endfunction : addr_valid

  // Handler start pulse is taken uninverted so its deassertion edge, the rising edge of the pin, is detected
  // Idle high pin: synchroniser resets high so no false rise follows reset
  sync_edge #(.IDLE(1'b1)) u_trig_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (external_start_pulse_n),
    .level   (trig_level),
    .rise    (trig_rise)
  );

  // Lockout is asserted low; synchronise the inverted level
  sync_edge u_lock_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (~panel_lockout_n),
    .level   (lock_level),
    .rise    (lock_rise)
  );

  result_encode u_enc (
    .list_mode (list_mode),
    .res       (result),
    .pins      (next_pins)
  );

  // Low-time qualifier: pulses shorter than the least width are treated as glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_cnt <= 8'h00;
    else if (ce)
    begin
      if (trig_level)
        pulse_cnt <= 8'h00;
      else if (pulse_cnt != 8'hFF)
        pulse_cnt <= pulse_cnt + 8'h01;
    end
  end
  assign pulse_ok = (pulse_cnt >= 8'(TRIG_MIN_CYC));

  // APB answers in the access cycle with no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else if (ce)
      pready <= psel & ~penable;
  end

  // Error is raised with ready so the master sees both at the same edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else if (ce)
      pslverr <= psel & ~penable & ~addr_valid(paddr);
  end

  // Control register; arming is cleared when a trigger starts the measurement
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= CTRL_RESET;
    else if (ce)
    begin
      if (wr && paddr == OFF_CTRL && pready)
        ctrl <= pwdata;
      else if (measure_start)
        ctrl[CTRL_ARMED] <= 1'b0;
    end
  end

  // Start only on a qualified rising edge while armed in external mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      measure_start <= 1'b0;
    else if (ce)
      measure_start <= trig_rise & pulse_ok & ext_mode & armed & ~measure_start;
  end

  // Result word may only change while cycle-done is not asserted
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result <= '0;
    else if (ce && wr && pready && paddr == OFF_RESULT && !cycle_done)
      result <= result_t'(pwdata[$bits(result_t)-1:0]);
  end

  // Pins are refreshed from the encoder while no cycle is reported done
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_pins <= PINS_IDLE;
    else if (ce && !cycle_done)
      result_pins <= next_pins;
  end

  // Analog-done: the fixture may be reloaded; a new cycle clears it first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_done <= 1'b0;
    else if (ce)
    begin
      if (new_cycle)
        analog_done <= 1'b0;
      else if (stb_wr && pready && pwdata[STB_ANALOG_DONE])
        analog_done <= 1'b1;
    end
  end

  // Cycle-done: results valid; a new cycle clears it so stale data never shows done
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cycle_done <= 1'b0;
    else if (ce)
    begin
      if (new_cycle)
        cycle_done <= 1'b0;
      else if (stb_wr && pready && pwdata[STB_CYCLE_DONE])
        cycle_done <= 1'b1;
    end
  end

  // Alarm comes up after reset and on power fail; software clears it, a new fail wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alarm <= 1'b1;
    else if (ce && stb_wr && pready)
    begin
      if (pwdata[STB_POWER_FAIL])
        alarm <= 1'b1;
      else if (pwdata[STB_ALARM_CLR])
        alarm <= 1'b0;
    end
  end

  // Handler control pins, all active low and deasserted in reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_done_n <= 1'b1;
    else if (ce)
      analog_done_n <= ~analog_done;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cycle_done_n <= 1'b1;
    else if (ce)
      cycle_done_n <= ~cycle_done;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_alert_n <= 1'b1;
    else if (ce)
      fault_alert_n <= ~alarm;
  end

  // Dropped at the edge that ends the start cycle so a second edge cannot be invited
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trigger_accept_n <= 1'b1;
    else if (ce)
      trigger_accept_n <= ~(ext_mode & armed & ~measure_start);
  end

  // Key gating: held keys are dropped the whole time lockout is seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      panel_keys_gated <= 8'h00;
    else if (ce)
      panel_keys_gated <= lock_level ? 8'h00 : panel_keys;
  end

  // Sticky interrupt status; an event in the clearing cycle wins
  wire [IRQ_NUM-1:0] irq_clr = (wr && pready && paddr == OFF_IRQ_STAT) ? pwdata[IRQ_NUM-1:0] : '0;
  wire [IRQ_NUM-1:0] irq_set = {lock_rise, measure_start};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat <= IRQ_RESET;
    else if (ce)
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= IRQ_RESET;
    else if (ce && wr && pready && paddr == OFF_IRQ_MASK)
      irq_mask <= pwdata[IRQ_NUM-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else if (ce)
      irq <= |(irq_stat & irq_mask);
  end

  // Read data registered in the setup cycle so it is valid throughout access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (ce && psel && !penable && !pwrite)
    begin
      unique case (paddr)
        OFF_CTRL:     prdata <= ctrl;
        OFF_RESULT:   prdata <= 32'(result);
        OFF_STATUS:   prdata <= {26'h0, lock_level, alarm, cycle_done, analog_done,
                                 ~trigger_accept_n, trig_level};
        OFF_IRQ_STAT: prdata <= 32'(irq_stat);
        OFF_IRQ_MASK: prdata <= 32'(irq_mask);
        default:      prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : handler_sort_result_interface
`default_nettype wire

// ### handler_sort_result_interface_bench.sv
// Directed bench for the handler sort result interface
`timescale 1ns/1ps
`default_nettype none
module handler_sort_result_interface_bench
  import handler_pkg::*;
;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         ce = 1'b1;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0000_0000;
  logic [7:0]   panel_keys = 8'h00;
  logic [7:0]   panel_keys_gated;
  logic [31:0]  prdata, rd;
  logic         pready, pslverr, irq, measure_start, err;
  logic         analog_done_n, cycle_done_n, fault_alert_n, trigger_accept_n;
  logic         external_start_pulse_n, panel_lockout_n;
  result_pins_t result_pins, exp_pins;
  int           starts = 0;
  int           n_mismatch = 0;
  int           samples_checked = 0;

  initial
  begin
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (measure_start)
      starts <= starts + 1;

  handler_sort_result_interface DUT (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .irq, .external_start_pulse_n, .panel_lockout_n, .panel_keys, .panel_keys_gated,
    .measure_start, .result_pins, .analog_done_n, .cycle_done_n, .fault_alert_n, .trigger_accept_n
  );

  handler_model u_hdl (.pclk, .external_start_pulse_n, .panel_lockout_n, .result_pins, .cycle_done_n);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // One transfer; the request stands until pready is sampled high at a rising edge, failing the run after 20 edges without it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int   k;
    logic ok;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    ok  = (pready === 1'b1);
    err = pslverr;
    rd  = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (!ok)
    begin
      n_mismatch++;
      conclude();
    end
  endtask : apb

  initial
  begin
    tick(20);
    presetn <= 1'b1;
    tick(3);
    check("alarm", 32'(fault_alert_n), 32'h0);
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrl", rd, CTRL_RESET);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, OFF_STROBE, 32'h8);
    tick(2);
    check("alarm", 32'(fault_alert_n), 32'h1);
    apb(1'b1, OFF_STROBE, 32'h4);
    tick(2);
    check("alarm", 32'(fault_alert_n), 32'h0);
    for (int c = 1; c <= 11; c++)
    begin
      apb(1'b1, OFF_STROBE, 32'h10);
      apb(1'b1, OFF_RESULT, {24'h0, c[3:0], c[3:0]});
      apb(1'b1, OFF_STROBE, 32'h1);
      apb(1'b1, OFF_STROBE, 32'h2);
      tick(2);
      exp_pins = PINS_IDLE;
      if (c <= 9)
        exp_pins.sort_class_n[c-1] = 1'b0;
      exp_pins.no_class_match_n = (c != 10);
      exp_pins.aux_class_n = (c != 11);
      {exp_pins.measure_overload_n, exp_pins.secondary_reject_n, exp_pins.primary_below_limit_n,
       exp_pins.primary_above_limit_n} = ~c[3:0];
      check("done", {analog_done_n, cycle_done_n}, 32'h0);
      check("pins", 32'(u_hdl.seen), 32'(exp_pins));
    end
    apb(1'b1, OFF_RESULT, 32'h0000_0001);
    tick(3);
    check("held", 32'(result_pins), 32'(exp_pins));
    apb(1'b1, OFF_STROBE, 32'h10);
    apb(1'b1, OFF_CTRL, 32'h2);
    apb(1'b1, OFF_RESULT, 32'h0002_A511);
    apb(1'b1, OFF_STROBE, 32'h2);
    tick(2);
    exp_pins = PINS_IDLE;
    exp_pins.sort_class_n = ~9'h0A5;
    exp_pins.no_class_match_n = 1'b0;
    exp_pins.aux_class_n = 1'b0;
    check("list", 32'(u_hdl.seen), 32'(exp_pins));
    apb(1'b1, OFF_CTRL, 32'h5);
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    check("accept", 32'(trigger_accept_n), 32'h0);
    u_hdl.pulse(TRIG_MIN_CYC);
    for (int k = 0; k < 20 && starts == 0; k++)
      tick(1);
    tick(2);
    check("starts", starts, 1);
    check("accept", {trigger_accept_n, irq}, 32'h3);
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    tick(2);
    check("irq", 32'(irq), 32'h0);
    apb(1'b1, OFF_CTRL, 32'h4);
    check("accept", 32'(trigger_accept_n), 32'h1);
    u_hdl.pulse(TRIG_MIN_CYC);
    tick(10);
    check("starts", starts, 1);
    panel_keys <= 8'h5A;
    u_hdl.lock(1'b1);
    tick(6);
    check("keys", 32'(panel_keys_gated), 32'h0);
    apb(1'b0, OFF_IRQ_STAT, 32'h0);
    check("irq", {irq, rd[30:0]}, 32'h2);
    u_hdl.lock(1'b0);
    tick(6);
    check("keys", 32'(panel_keys_gated), 32'h5A);
    ce         <= 1'b0;
    panel_keys <= 8'h3C;
    tick(4);
    check("frozen", 32'(panel_keys_gated), 32'h5A);
    ce <= 1'b1;
    tick(2);
    check("keys", 32'(panel_keys_gated), 32'h3C);
    conclude();
  end
endmodule : handler_sort_result_interface_bench
`default_nettype wire

// ### result_encode.sv
// Maps a result word onto the active-low handler result pins for either comparator mode
`timescale 1ns/1ps
`default_nettype none
module result_encode
  import handler_pkg::*;
(
  input  wire logic    list_mode,
  input  var  result_t res,
  output result_pins_t pins
);

  function automatic logic [CLASS_N-1:0] class_onehot(input logic [3:0] code);
    logic [CLASS_N-1:0] v;
    v = '0;
    for (int i = 0; i < CLASS_N; i++)
      if (code == 4'(i + 1))
        v[i] = 1'b1;
    return v;
  endfunction : class_onehot

  always_comb
  begin
    pins = PINS_IDLE;
    if (list_mode)
    begin
      // Sweep in/out results replace the class lines
      pins.sort_class_n     = ~res.sweep_bits[CLASS_N-1:0];
      pins.no_class_match_n = ~res.sweep_bits[9];
      pins.aux_class_n      = ~res.prim_above;
    end
    else
    begin
      // Exactly one class, no-match or aux line; illegal codes fall to no-match
      pins.sort_class_n     = ~class_onehot(res.class_code);
      pins.aux_class_n      = ~(res.class_code == CODE_AUX);
      pins.no_class_match_n = ~((class_onehot(res.class_code) == '0) && (res.class_code != CODE_AUX));
      pins.primary_above_limit_n = ~res.prim_above;
      pins.primary_below_limit_n = ~res.prim_below;
      pins.secondary_reject_n    = ~res.sec_reject;
    end
    pins.measure_overload_n = ~res.overload;
  end

endmodule : result_encode
`default_nettype wire

// ### sync_edge.sv
// Two flip-flop synchroniser with a rising-edge detector after the second stage
`timescale 1ns/1ps
`default_nettype none
module sync_edge
  import handler_pkg::*;
#(
  // Level of the pin while idle, so reset does not fake an edge
  parameter logic IDLE = 1'b0
)
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Asynchronous level and its synchronised view
  input  wire logic din,
  output logic      level,
  output logic      rise
);

  logic meta;
  logic prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta  <= IDLE;
      level <= IDLE;
      prev  <= IDLE;
    end
    else if (ce)
    begin
      meta  <= din;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = ce & level & ~prev;

endmodule : sync_edge
`default_nettype wire
